// ===== pkg/fsp_cfg.svh
// fsp_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the host controller; 100 MHz core clock
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// register offsets (byte addresses, one aligned word each)
`define FSP_OFF_CTRL 12'h000
`define FSP_OFF_ADDR 12'h004
`define FSP_OFF_DATA 12'h008
`define FSP_OFF_STAT 12'h00C
`define FSP_OFF_RDAT 12'h010

// control register fields
`define FSP_CTRL_GO 0
`define FSP_CTRL_OP_LO 1
`define FSP_CTRL_OP_HI 3
`define FSP_CTRL_MODE 4

// status register fields
`define FSP_ST_BUSY 0
`define FSP_ST_DONE 1
`define FSP_ST_FAIL 2
`define FSP_ST_REJ 3
`define FSP_ST_PROT 4

// operation codes
`define FSP_OP_READ 3'h0
`define FSP_OP_WRITE 3'h1
`define FSP_OP_POLL 3'h2
`define FSP_OP_ERADD 3'h3
`define FSP_OP_PVER 3'h4

// flash status bit positions on the data bus
`define FSP_BIT_TOG 6
`define FSP_BIT_TMO 5
`define FSP_BIT_WIN 3
`define FSP_BIT_SETG 2

// reset command and reset values
`define FSP_CMD_RESET 8'hF0
`define FSP_RST_WORD 32'h0000_0000

// strobe timing: 60 ns pulse, well above the 5 ns glitch filter
`define FSP_T_PULSE_NS 60
`define FSP_CLK_NS 10
`define FSP_PULSE_CYC ((`FSP_T_PULSE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// ===== pkg/fsp_pkg.sv
// fsp_pkg.sv: types of the flash status host controller
// assumes: fsp_cfg.svh on the include path
`include "fsp_cfg.svh"
package fsp_pkg;

   // ---------------------------------------------
   // flash pin bundle
   // ---------------------------------------------
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic hv_req;
      logic [19:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
   } fsp_pins_type;

   typedef enum logic [3:0] {
      FSP_IDLE, FSP_WSET, FSP_WPUL, FSP_WEND, FSP_RSET, FSP_RPUL, FSP_REND,
      FSP_DECIDE, FSP_RSTCMD
   } fsp_state_type;

   typedef enum logic [1:0] {
      FSP_PH_FIRST, FSP_PH_SECOND, FSP_PH_RECHECK, FSP_PH_WIN
   } fsp_phase_type;

   typedef struct packed {
      fsp_state_type st;
      fsp_phase_type ph;
      logic [2:0] op;
      logic mode;
      logic [3:0] cnt;
      logic [19:0] addr;
      logic [7:0] wdat;
      logic [7:0] prev;
      logic [7:0] rdat;
      logic busy;
      logic done;
      logic fail;
      logic rej;
      logic prot;
      fsp_pins_type pins;
      logic awr_ok;
      logic wr_ok;
      logic bvalid;
      logic rvalid;
      logic [31:0] rd;
   } fsp_state_vec_type;

endpackage

// ===== rtl/fsp_host.sv
// fsp_host.sv: host controller driving a parallel flash through its strobes
// assumes: AXI4-Lite master in the same clock; flash data pins are synchronous
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`include "fsp_cfg.svh"

module fsp_host (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // axi4-lite slave
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // flash pins
   output fsp_pkg::fsp_pins_type flash_pins,
   input wire logic [7:0] flash_dq_in
);
   import fsp_pkg::*;

   fsp_state_vec_type state_ff;
   fsp_state_vec_type nxt_state;
   logic aw_go;
   logic ar_go;
   logic [7:0] status_word;

   // -------------------------------------------------
   // bus handshakes
   // -------------------------------------------------
   // address and data are taken together so a write is never split
   // nothing is taken while frozen: a ready seen then would drop the request
   assign aw_go = clk_en && s_awvalid && s_wvalid && !state_ff.bvalid;
   assign ar_go = clk_en && s_arvalid && !state_ff.rvalid;
   assign s_awready = aw_go;
   assign s_wready = aw_go;
   assign s_arready = ar_go;
   assign s_bvalid = state_ff.bvalid;
   assign s_bresp = 2'b00;
   assign s_rvalid = state_ff.rvalid;
   assign s_rdata = state_ff.rd;
   assign s_rresp = 2'b00;
   assign flash_pins = state_ff.pins;
   assign status_word = {3'b000, state_ff.prot, state_ff.rej, state_ff.fail,
                         state_ff.done, state_ff.busy};

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      // bus response channels
      if (state_ff.bvalid && s_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      if (state_ff.rvalid && s_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      if (ar_go) begin
         nxt_state.rvalid = 1'b1;
         case (s_araddr)
            `FSP_OFF_CTRL: nxt_state.rd = {27'h000_0000, state_ff.mode, state_ff.op, 1'b0};
            `FSP_OFF_ADDR: nxt_state.rd = {12'h000, state_ff.addr};
            `FSP_OFF_DATA: nxt_state.rd = {24'h00_0000, state_ff.wdat};
            `FSP_OFF_STAT: nxt_state.rd = {24'h00_0000, status_word};
            `FSP_OFF_RDAT: nxt_state.rd = {24'h00_0000, state_ff.rdat};
            default: nxt_state.rd = `FSP_RST_WORD;
         endcase
      end
      if (aw_go) begin
         nxt_state.bvalid = 1'b1;
         case (s_awaddr)
            `FSP_OFF_ADDR: if (s_wstrb != 4'h0) nxt_state.addr = s_wdata[19:0];
            `FSP_OFF_DATA: if (s_wstrb[0]) nxt_state.wdat = s_wdata[7:0];
            `FSP_OFF_CTRL: begin
               if (s_wstrb[0] && state_ff.st == FSP_IDLE) begin
                  nxt_state.op = s_wdata[`FSP_CTRL_OP_HI:`FSP_CTRL_OP_LO];
                  nxt_state.mode = s_wdata[`FSP_CTRL_MODE];
                  if (s_wdata[`FSP_CTRL_GO]) begin
                     nxt_state.busy = 1'b1;
                     nxt_state.done = 1'b0;
                     nxt_state.fail = 1'b0;
                     nxt_state.rej = 1'b0;
                     nxt_state.ph = FSP_PH_FIRST;
                     if (s_wdata[`FSP_CTRL_OP_HI:`FSP_CTRL_OP_LO] == `FSP_OP_ERADD) begin
                        nxt_state.ph = FSP_PH_WIN;
                     end
                     if (s_wdata[`FSP_CTRL_OP_HI:`FSP_CTRL_OP_LO] == `FSP_OP_WRITE) begin
                        nxt_state.st = FSP_WSET;
                     end else begin
                        nxt_state.st = FSP_RSET;
                     end
                  end
               end
            end
            default: ;
         endcase
      end
      // flash sequencer
      case (state_ff.st)
         FSP_IDLE: begin
            nxt_state.pins.ce_n = 1'b1;
            nxt_state.pins.oe_n = 1'b1;
            nxt_state.pins.we_n = 1'b1;
            nxt_state.pins.dq_oe = 1'b0;
         end
         FSP_WSET: begin
            nxt_state.pins.oe_n = 1'b1;
            nxt_state.pins.addr = state_ff.addr;
            nxt_state.pins.dq_out = state_ff.wdat;
            nxt_state.pins.dq_oe = 1'b1;
            nxt_state.pins.hv_req = state_ff.mode;
            nxt_state.cnt = 4'(`FSP_PULSE_CYC);
            nxt_state.st = FSP_WPUL;
         end
         FSP_WPUL: begin
            nxt_state.pins.ce_n = 1'b0;
            nxt_state.pins.we_n = 1'b0;
            nxt_state.cnt = state_ff.cnt - 4'h1;
            if (state_ff.cnt == 4'h1) begin
               nxt_state.st = FSP_WEND;
            end
         end
         FSP_WEND: begin
            // each write is one full cycle
            nxt_state.pins.we_n = 1'b1;
            nxt_state.pins.ce_n = 1'b1;
            nxt_state.pins.dq_oe = 1'b0;
            nxt_state.pins.hv_req = 1'b0;
            nxt_state.busy = 1'b0;
            nxt_state.done = 1'b1;
            nxt_state.st = FSP_IDLE;
         end
         FSP_RSET: begin
            nxt_state.pins.addr = state_ff.addr;
            nxt_state.pins.dq_oe = 1'b0;
            nxt_state.pins.hv_req = state_ff.mode && (state_ff.op == `FSP_OP_PVER);
            nxt_state.cnt = 4'(`FSP_PULSE_CYC);
            nxt_state.st = FSP_RPUL;
         end
         FSP_RPUL: begin
            nxt_state.pins.ce_n = 1'b0;
            nxt_state.pins.oe_n = 1'b0;
            nxt_state.cnt = state_ff.cnt - 4'h1;
            if (state_ff.cnt == 4'h1) begin
               nxt_state.rdat = flash_dq_in;
               nxt_state.prev = state_ff.rdat;
               nxt_state.st = FSP_REND;
            end
         end
         FSP_REND: begin
            nxt_state.pins.ce_n = 1'b1;
            nxt_state.pins.oe_n = 1'b1;
            nxt_state.pins.hv_req = 1'b0;
            nxt_state.st = FSP_DECIDE;
         end
         FSP_DECIDE: begin
            nxt_state.st = FSP_IDLE;
            nxt_state.busy = 1'b0;
            nxt_state.done = 1'b1;
            case (state_ff.op)
               `FSP_OP_PVER: begin
                  nxt_state.prot = state_ff.rdat[0];
               end
               `FSP_OP_ERADD: begin
                  nxt_state.rej = state_ff.rdat[`FSP_BIT_WIN];
               end
               `FSP_OP_POLL: begin
                  if (state_ff.ph == FSP_PH_FIRST) begin
                     nxt_state.ph = FSP_PH_SECOND;
                     nxt_state.st = FSP_RSET;
                     nxt_state.busy = 1'b1;
                     nxt_state.done = 1'b0;
                  end else if (state_ff.rdat[`FSP_BIT_TOG] == state_ff.prev[`FSP_BIT_TOG]) begin
                     nxt_state.fail = 1'b0;
                  end else if (state_ff.ph == FSP_PH_RECHECK) begin
                     nxt_state.fail = 1'b1;
                     nxt_state.st = FSP_RSTCMD;
                     nxt_state.busy = 1'b1;
                     nxt_state.done = 1'b0;
                  end else if (state_ff.rdat[`FSP_BIT_TMO]) begin
                     nxt_state.ph = FSP_PH_RECHECK;
                     nxt_state.st = FSP_RSET;
                     nxt_state.busy = 1'b1;
                     nxt_state.done = 1'b0;
                  end else begin
                     // still busy; software re-issues poll later
                     nxt_state.ph = FSP_PH_FIRST;
                     nxt_state.done = 1'b0;
                  end
               end
               default: ;
            endcase
         end
         FSP_RSTCMD: begin
            nxt_state.wdat = `FSP_CMD_RESET;
            nxt_state.st = FSP_WSET;
         end
         default: nxt_state.st = FSP_IDLE;
      endcase
   end

   // -------------------------------------------------
   // state register
   // -------------------------------------------------
   // reset leaves pins idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= '0;
         state_ff.st <= FSP_IDLE;
         state_ff.pins.ce_n <= 1'b1;
         state_ff.pins.oe_n <= 1'b1;
         state_ff.pins.we_n <= 1'b1;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   property p_wr_inhibit;
      @(posedge core_clk) disable iff (rst)
      !state_ff.pins.we_n |-> (state_ff.pins.oe_n && !state_ff.pins.ce_n);
   endproperty
   a_wr_inhibit: assert property (p_wr_inhibit) else $error("write with oe low");

   property p_pulse_len;
      @(posedge core_clk) disable iff (rst)
      (clk_en && $fell(state_ff.pins.we_n)) |-> !state_ff.pins.we_n [*6];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short");

   property p_fail_reset;
      @(posedge core_clk) disable iff (rst)
      (state_ff.st == FSP_RSTCMD) |=> (state_ff.wdat == 8'hF0);
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("no reset command");

   property p_prot;
      @(posedge core_clk) disable iff (rst)
      (clk_en && state_ff.st == FSP_DECIDE && state_ff.op == `FSP_OP_PVER)
      |=> (state_ff.prot == $past(state_ff.rdat[0]));
   endproperty
   a_prot: assert property (p_prot) else $error("protect bit wrong");

   property p_rej;
      @(posedge core_clk) disable iff (rst)
      (clk_en && state_ff.st == FSP_DECIDE && state_ff.op == `FSP_OP_ERADD)
      |=> (state_ff.rej == $past(state_ff.rdat[3]));
   endproperty
   a_rej: assert property (p_rej) else $error("window flag lost");

   property p_second_read;
      @(posedge core_clk) disable iff (rst)
      (clk_en && state_ff.st == FSP_DECIDE && state_ff.op == `FSP_OP_POLL
       && state_ff.ph == FSP_PH_FIRST) |=> (state_ff.st == FSP_RSET);
   endproperty
   a_second_read: assert property (p_second_read) else $error("single read poll");

   property p_hv_off;
      @(posedge core_clk) disable iff (rst)
      (state_ff.st == FSP_IDLE && $past(state_ff.st) == FSP_IDLE) |-> !state_ff.pins.hv_req;
   endproperty
   a_hv_off: assert property (p_hv_off) else $error("high voltage left on");

   property p_bresp;
      @(posedge core_clk) disable iff (rst)
      (clk_en && aw_go) |=> s_bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("no write response");

   c_write: cover property (@(posedge core_clk) state_ff.st == FSP_WEND);
   c_fail: cover property (@(posedge core_clk) state_ff.st == FSP_RSTCMD);
   c_poll_done: cover property (@(posedge core_clk) state_ff.done && state_ff.op == `FSP_OP_POLL);
endmodule

// ===== test/fsp_flash_model.sv
// fsp_flash_model.sv: behavioural parallel flash, status bits and protection
// assumes: pins registered on core_clk, so strobe edges line up with clock edges
`include "fsp_cfg.svh"
module fsp_flash_model
   import fsp_pkg::*;
(
   // clock and flash pins
   input wire logic core_clk,
   input wire fsp_pkg::fsp_pins_type pins,
   output logic [7:0] dq
);
   timeunit 1ns;
   timeprecision 1ps;
   int busy_left = 0;
   int n_wr = 0;
   logic tmo = 1'b0, win = 1'b0, prot = 1'b0, saw_hv = 1'b0, tog = 1'b0, etog = 1'b0;
   logic [7:0] mem [16];
   logic [7:0] out_b, last_out = 8'h00, last_wd = 8'h00;
   logic [19:0] last_wa = 20'h0_0000;
   fsp_pins_type prev = '1;

   // byte offered on a read cycle
   always_comb begin
      if (busy_left > 0)
         out_b = {~mem[pins.addr[3:0]][7], tog, tmo, 1'b0, win, etog, 2'b00};
      else if (pins.hv_req)
         out_b = {7'h00, prot & pins.addr[1]};
      else
         out_b = mem[pins.addr[3:0]];
   end

   // released bus shows the inverse, so a stale sample never looks right
   assign dq = (!pins.ce_n && !pins.oe_n) ? out_b : ~last_out;

   // strobe edges are judged against the previous pin state
   always @(posedge core_clk) begin
      if (!pins.ce_n && !pins.oe_n)
         last_out = out_b;
      if (pins.hv_req)
         saw_hv = 1'b1;
      if (!prev.ce_n && !prev.oe_n && pins.oe_n && busy_left > 0) begin
         tog = ~tog;
         etog = ~etog;
         if (!tmo)
            busy_left = busy_left - 1;
      end
      // write needs ce, we low, oe high
      // strobes last whole cycles, no glitch gets here
      if (!prev.ce_n && !prev.we_n && prev.oe_n && pins.we_n) begin
         last_wa = prev.addr;
         last_wd = prev.dq_out;
         n_wr++;
         // a write never raises the timeout flag
         // reset command back to array read
         if (prev.dq_out == `FSP_CMD_RESET) begin
            busy_left = 0;
            tmo = 1'b0;
         end
         else if (!(win && busy_left > 0) && !(prot && !prev.hv_req))
            mem[prev.addr[3:0]] = prev.dq_out;
      end
      prev = pins;
   end
endmodule

// ===== test/tb_top.sv
// tb_top.sv: self-checking bench of the flash host controller
// assumes: fsp_flash_model on the flash side; register map from fsp_cfg.svh
`include "fsp_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
   logic [31:0] s_wdata = 32'h0000_0000;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata, st;
   fsp_pins_type flash_pins;
   logic [7:0] flash_dq_in;
   int failures = 0, n_compared = 0, cyc = 0;

   fsp_host fsp_host_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
   fsp_flash_model fsp_flash_model_inst (.core_clk(core_clk), .pins(flash_pins),
      .dq(flash_dq_in));

   // ---------------------------------------------
   // clock, hang guard and shared tasks
   // ---------------------------------------------
   always #5 core_clk = ~core_clk;
   // whole run needs a few hundred cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // write: address and data offered together, bready held until bvalid
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      d = s_rdata;
      s_rready <= 1'b0;
   endtask

   // start one operation, then read status until busy drops
   task automatic run_op(input logic [2:0] op, input logic md);
      axi_wr(`FSP_OFF_CTRL, {27'h000_0000, md, op, 1'b1});
      do begin
         axi_rd(`FSP_OFF_STAT, st);
      end while (st[0] !== 1'b0);
   endtask

   // knobs change away from the edge the model runs on
   task automatic knobs(input int bl, input logic t, input logic w, input logic p);
      @(negedge core_clk);
      fsp_flash_model_inst.busy_left = bl;
      fsp_flash_model_inst.tmo = t;
      fsp_flash_model_inst.win = w;
      fsp_flash_model_inst.prot = p;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset;
      chk(32'({flash_pins.ce_n, flash_pins.oe_n, flash_pins.we_n, flash_pins.dq_oe}), 32'hE);
      axi_rd(`FSP_OFF_STAT, st);
      chk(st, `FSP_RST_WORD);
      axi_rd(12'h0FC, st);
      chk(st, 32'h0000_0000);
   endtask

   task automatic t_wr_rd;
      axi_wr(`FSP_OFF_ADDR, 32'h0000_0003);
      // data write offered while frozen; it must wait, not vanish
      @(posedge core_clk);
      clk_en <= 1'b0;
      fork
         axi_wr(`FSP_OFF_DATA, 32'h0000_005A);
         begin
            repeat (4) @(posedge core_clk);
            clk_en <= 1'b1;
         end
      join
      run_op(`FSP_OP_WRITE, 1'b0);
      chk(32'(fsp_flash_model_inst.last_wd), 32'h5A);
      chk(32'(fsp_flash_model_inst.last_wa), 32'h3);
      run_op(`FSP_OP_READ, 1'b0);
      axi_rd(`FSP_OFF_RDAT, st);
      chk(st, 32'h0000_005A);
   endtask

   task automatic t_poll;
      int n0;
      knobs(0, 1'b0, 1'b0, 1'b0);
      run_op(`FSP_OP_POLL, 1'b0);
      chk(32'(st[2:1]), 32'h1);
      knobs(100, 1'b0, 1'b0, 1'b0);
      run_op(`FSP_OP_POLL, 1'b0);
      chk(32'(st[2:1]), 32'h0);
      knobs(0, 1'b0, 1'b0, 1'b0);
      run_op(`FSP_OP_POLL, 1'b0);
      chk(32'(st[2:1]), 32'h1);
      knobs(100, 1'b1, 1'b0, 1'b0);
      n0 = fsp_flash_model_inst.n_wr;
      run_op(`FSP_OP_POLL, 1'b0);
      chk(32'(st[2:1]), 32'h3);
      chk(32'(fsp_flash_model_inst.last_wd), 32'hF0);
      chk(32'(fsp_flash_model_inst.n_wr - n0), 32'h1);
   endtask

   task automatic t_window;
      knobs(10, 1'b0, 1'b1, 1'b0);
      run_op(`FSP_OP_ERADD, 1'b0);
      chk(32'(st[3]), 32'h1);
      knobs(10, 1'b0, 1'b0, 1'b0);
      run_op(`FSP_OP_ERADD, 1'b0);
      chk(32'(st[3]), 32'h0);
   endtask

   task automatic t_protect;
      knobs(0, 1'b0, 1'b0, 1'b1);
      axi_wr(`FSP_OFF_ADDR, 32'h0000_0002);
      run_op(`FSP_OP_PVER, 1'b1);
      chk(32'(st[4]), 32'h1);
      chk(32'(fsp_flash_model_inst.saw_hv), 32'h1);
      axi_wr(`FSP_OFF_ADDR, 32'h0000_0000);
      run_op(`FSP_OP_PVER, 1'b1);
      chk(32'(st[4]), 32'h0);
      // with prot set, a write with high voltage lands; the next write, without it, is refused
      axi_wr(`FSP_OFF_ADDR, 32'h0000_0005);
      axi_wr(`FSP_OFF_DATA, 32'h0000_0033);
      run_op(`FSP_OP_WRITE, 1'b1);
      axi_wr(`FSP_OFF_DATA, 32'h0000_0044);
      run_op(`FSP_OP_WRITE, 1'b0);
      run_op(`FSP_OP_READ, 1'b0);
      axi_rd(`FSP_OFF_RDAT, st);
      chk(st, 32'h0000_0033);
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_wr_rd();
      t_poll();
      t_window();
      t_protect();
      report_and_stop();
   end
endmodule
